/* include/lbs_pkg.sv */
// package: register map, field layout, reset values and timing of the bias block
package lbs_pkg;
  // register offsets
  localparam logic [7:0] ADDR_REF_TARGET = 8'h0F;
  localparam logic [7:0] ADDR_POS_SEQ    = 8'h10;
  localparam logic [7:0] ADDR_NEG_SEQ    = 8'h11;
  localparam logic [7:0] ADDR_REF_SEQ    = 8'h12;
  localparam logic [7:0] ADDR_FLAG_CFG   = 8'h13;
  localparam logic [7:0] ADDR_SOFT_RST   = 8'h14;
  localparam logic [7:0] ADDR_REVISION   = 8'h16;
  localparam logic [7:0] SOFT_RST_KEY    = 8'hFF;

  // reset values
  localparam logic [5:0] RST_REF_TARGET = 6'h00;
  localparam logic [7:0] RST_SEQ        = 8'h00;
  localparam logic [4:0] RST_FLAG_CFG   = 5'h00;

  // field positions and widths
  localparam int TARGET_W     = 6;
  localparam int DLY_W        = 4;
  localparam int SU_LSB       = 4;
  localparam int SD_LSB       = 0;
  localparam int FLAG_W       = 5;
  localparam int FLAG_POL_BIT = 4;
  localparam int PG_SEL_LSB   = 2;
  localparam int FUNC_LSB     = 0;
  localparam int NUM_SUP      = 3;
  localparam int SUP_POS      = 0;
  localparam int SUP_NEG      = 1;
  localparam int SUP_REF      = 2;

  // reference level: base, step, ceiling code
  localparam logic [5:0] REF_CODE_MAX = 6'h28;
  localparam int         REF_BASE_MV  = 4000;
  localparam int         REF_STEP_MV  = 50;
  localparam int         MV_W         = 13;

  // timing: one delay step is one millisecond at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int DLY_STEP_MS   = 1;
  localparam int CYC_PER_MS    = DLY_STEP_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {FN_NONE, FN_POWER_GOOD, FN_BACKLIGHT, FN_FAULT} lbs_func_t;
  typedef enum logic [1:0] {PG_LAST, PG_POS, PG_NEG, PG_REF} lbs_pg_sel_t;
endpackage

/* verilog/lbs_supply_seq.sv */
// one supply's start-up and shutdown delay sequencer
`timescale 1ns/10ps
module lbs_supply_seq import lbs_pkg::*; #(
  parameter int CYC_MS = CYC_PER_MS,
  parameter int CNT_W  = 24
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             want,
  input  wire logic [DLY_W-1:0] su_code,
  input  wire logic [DLY_W-1:0] sd_code,
  output logic                  on
);
  typedef enum logic [1:0] {SQ_OFF, SQ_UP, SQ_ON, SQ_DOWN} lbs_seq_t;

  lbs_seq_t         st;
  lbs_seq_t         next_st;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] target;
  logic             next_on;

  // delay as cycles, start-up from enable, shutdown from disable event
  always_comb begin
    target = (st == SQ_DOWN) ? CNT_W'(int'(sd_code) * CYC_MS)
                             : CNT_W'(int'(su_code) * CYC_MS);
    next_st  = st;
    next_cnt = cnt + 1'h1;
    case (st)
      SQ_OFF: begin
        next_cnt = '0;
        if (want) next_st = SQ_UP;
      end
      SQ_UP: begin
        if (!want) begin
          next_st  = SQ_OFF;
          next_cnt = '0;
        end else if (cnt >= target) begin
          next_st  = SQ_ON;
          next_cnt = '0;
        end
      end
      SQ_ON: begin
        next_cnt = '0;
        if (!want) next_st = SQ_DOWN;
      end
      default: begin
        if (want) begin
          next_st  = SQ_ON;
          next_cnt = '0;
        end else if (cnt >= target) begin
          next_st  = SQ_OFF;
          next_cnt = '0;
        end
      end
    endcase
    next_on = (next_st == SQ_ON) || (next_st == SQ_DOWN);
  end

  // state registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st  <= SQ_OFF;
      cnt <= '0;
      on  <= 1'h0;
    end else begin
      st  <= next_st;
      cnt <= next_cnt;
      on  <= next_on;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_start_now;
    (st == SQ_OFF && want) ##1 (want && su_code == '0);
  endsequence

  property p_on_after_delay;
    $rose(on) |-> $past(st) == SQ_UP && $past(cnt) >= $past(target);
  endproperty
  a_on_after_delay: assert property (p_on_after_delay)
    else $error("supply came on before its start-up delay");

  property p_off_after_delay;
    $fell(on) |-> $past(st) == SQ_DOWN && $past(cnt) >= $past(target);
  endproperty
  a_off_after_delay: assert property (p_off_after_delay)
    else $error("supply went off before its shutdown delay");

  property p_zero_delay;
    s_start_now |=> on;
  endproperty
  a_zero_delay: assert property (p_zero_delay)
    else $error("zero start-up delay did not turn supply on");
endmodule

/* verilog/lbs_bias_regs.sv */
// bias sequencing and indicator registers behind a two-wire serial slave
`timescale 1ns/10ps
// Contract
// - reference level is 4.00 V plus 50 mV per six-bit target code step.
// - target codes above the 6.00 V code clamp at 6.00 V.
// - positive supply register: start-up delay bits 7:4, shutdown 3:0, n ms.
// - negative pump register: start-up delay bits 7:4, shutdown 3:0, n ms.
// - reference supply register: start-up delay bits 7:4, shutdown 3:0, n ms.
// - indicator pin active low when polarity bit 4 is 0, else active high.
// - bits 1:0 pick indicator: none, power-good, backlight on, fault.
// - bits 3:2 pick power-good source: last enabled, positive, negative, reference.
// - writing FFh to soft reset register restores every register's reset value.
// - read-only revision: traceability 7:6, memory revision 5:3, silicon 2:0.
// - bias enable starts boost; outputs enable only after boost start.
// - backlight blocked until every enabled bias output has settled.
module lbs_bias_regs import lbs_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h36, // arbitrary bus address
  parameter logic [1:0] REV_DIE  = 2'h1,  // arbitrary value
  parameter logic [2:0] REV_OTP  = 3'h2,  // arbitrary value
  parameter logic [2:0] REV_SI   = 3'h3,  // arbitrary value
  parameter int         CYC_MS   = CYC_PER_MS
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe_n,
  input  wire logic                bias_enable_input,
  input  wire logic [NUM_SUP-1:0]  supply_enable,
  input  wire logic [NUM_SUP-1:0]  supply_ready,
  input  wire logic                fault_in,
  input  wire logic                backlight_active,
  output logic                     bias_boost_on,
  output logic [NUM_SUP-1:0]       supply_on,
  output logic [TARGET_W-1:0]      reference_ldo_target_code,
  output logic [MV_W-1:0]          ref_level_mv,
  output logic                     power_good,
  output logic                     backlight_allow,
  output logic                     indicator_pin
);
  typedef enum logic [2:0] {IC_IDLE, IC_ADDR, IC_PTR, IC_WR, IC_RD} lbs_i2c_t;

  logic [6:0]          sync1;
  logic [6:0]          sync2;
  logic                scl_d;
  logic                sda_d;
  logic                scl_s;
  logic                sda_s;
  logic                bias_en_s;
  logic                fault_s;
  logic [NUM_SUP-1:0]  ready_s;
  logic                scl_rise;
  logic                scl_fall;
  logic                i2c_start;
  logic                i2c_stop;
  lbs_i2c_t            ic_st;
  lbs_i2c_t            next_ic_st;
  logic [3:0]          bitcnt;
  logic [3:0]          next_bitcnt;
  logic [7:0]          shreg;
  logic [7:0]          next_shreg;
  logic [7:0]          ptr;
  logic [7:0]          next_ptr;
  logic                ack_ph;
  logic                next_ack_ph;
  logic                next_sda_oe_n;
  logic                wr_stb;
  logic [7:0]          rd_data;
  logic [TARGET_W-1:0] ref_target;
  logic [TARGET_W-1:0] next_ref_target;
  logic [7:0]          seq_cfg [NUM_SUP];
  logic [7:0]          next_seq_cfg [NUM_SUP];
  logic [FLAG_W-1:0]   flag_cfg;
  logic [FLAG_W-1:0]   next_flag_cfg;
  logic [NUM_SUP-1:0]  want;
  logic [NUM_SUP-1:0]  settled;
  logic                all_settled;
  logic                flag_active;
  logic [TARGET_W-1:0] clamp;
  logic                next_boost;
  logic                next_pg;
  logic                next_bl;
  logic                next_ind;
  logic [TARGET_W-1:0] next_code;
  logic [MV_W-1:0]     next_mv;

  // two-stage synchronisers for pins and analog status
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= 7'h03;
      sync2 <= 7'h03;
      scl_d <= 1'h1;
      sda_d <= 1'h1;
    end else begin
      sync1 <= {fault_in, supply_ready, bias_enable_input, sda_in, scl_in};
      sync2 <= sync1;
      scl_d <= sync2[0];
      sda_d <= sync2[1];
    end
  end

  assign scl_s     = sync2[0];
  assign sda_s     = sync2[1];
  assign bias_en_s = sync2[2];
  assign ready_s   = sync2[5:3];
  assign fault_s   = sync2[6];
  assign scl_rise  = scl_s && !scl_d;
  assign scl_fall  = !scl_s && scl_d;
  assign i2c_start = scl_s && scl_d && sda_d && !sda_s;
  assign i2c_stop  = scl_s && scl_d && !sda_d && sda_s;
  assign sda_out   = 1'h0;

  // read data; write-only and unmapped offsets read zero
  always_comb begin
    rd_data = 8'h00;
    if (ptr == ADDR_REF_TARGET) begin
      rd_data = {2'h0, ref_target};
    end else if (ptr >= ADDR_POS_SEQ && ptr <= ADDR_REF_SEQ) begin
      rd_data = seq_cfg[2'(ptr - ADDR_POS_SEQ)];
    end else if (ptr == ADDR_FLAG_CFG) begin
      rd_data = {3'h0, flag_cfg};
    end else if (ptr == ADDR_REVISION) begin
      rd_data = {REV_DIE, REV_OTP, REV_SI};
    end
  end

  // serial slave: address, pointer, write bytes or read bytes, auto-increment
  always_comb begin
    next_ic_st    = ic_st;
    next_bitcnt   = bitcnt;
    next_shreg    = shreg;
    next_ptr      = ptr;
    next_ack_ph   = ack_ph;
    next_sda_oe_n = sda_oe_n;
    wr_stb        = 1'h0;
    if (i2c_stop) begin
      next_ic_st    = IC_IDLE;
      next_sda_oe_n = 1'h1;
    end else if (i2c_start) begin
      next_ic_st    = IC_ADDR;
      next_bitcnt   = 4'h0;
      next_ack_ph   = 1'h0;
      next_sda_oe_n = 1'h1;
    end else if (ic_st == IC_RD) begin
      if (scl_rise && bitcnt < 4'h8) begin
        next_bitcnt = bitcnt + 4'h1;
      end else if (scl_rise && bitcnt == 4'h8) begin
        if (sda_s) next_ic_st = IC_IDLE;
        else next_bitcnt = 4'h9;
      end else if (scl_fall && bitcnt == 4'h9) begin
        next_shreg    = rd_data;
        next_sda_oe_n = rd_data[7];
        next_ptr      = ptr + 8'h01;
        next_bitcnt   = 4'h0;
      end else if (scl_fall && bitcnt == 4'h8) begin
        next_sda_oe_n = 1'h1;
      end else if (scl_fall && bitcnt != 4'h0) begin
        next_shreg    = {shreg[6:0], 1'h0};
        next_sda_oe_n = shreg[6];
      end
    end else if (ic_st != IC_IDLE) begin
      if (scl_rise && bitcnt < 4'h8) begin
        next_shreg  = {shreg[6:0], sda_s};
        next_bitcnt = bitcnt + 4'h1;
      end else if (scl_fall && ack_ph) begin
        next_ack_ph   = 1'h0;
        next_sda_oe_n = 1'h1;
        next_bitcnt   = 4'h0;
        if (ic_st == IC_ADDR && shreg[0]) begin
          next_ic_st    = IC_RD;
          next_shreg    = rd_data;
          next_sda_oe_n = rd_data[7];
          next_ptr      = ptr + 8'h01;
        end else if (ic_st == IC_ADDR) begin
          next_ic_st = IC_PTR;
        end else begin
          next_ic_st = IC_WR;
        end
      end else if (scl_fall && bitcnt == 4'h8) begin
        if (ic_st == IC_ADDR && shreg[7:1] != DEV_ADDR) begin
          next_ic_st = IC_IDLE;
        end else begin
          next_ack_ph   = 1'h1;
          next_sda_oe_n = 1'h0;
          if (ic_st == IC_PTR) next_ptr = shreg;
          if (ic_st == IC_WR) begin
            wr_stb   = 1'h1;
            next_ptr = ptr + 8'h01;
          end
        end
      end
    end
  end

  // serial slave registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ic_st    <= IC_IDLE;
      bitcnt   <= 4'h0;
      shreg    <= 8'h00;
      ptr      <= 8'h00;
      ack_ph   <= 1'h0;
      sda_oe_n <= 1'h1;
    end else begin
      ic_st    <= next_ic_st;
      bitcnt   <= next_bitcnt;
      shreg    <= next_shreg;
      ptr      <= next_ptr;
      ack_ph   <= next_ack_ph;
      sda_oe_n <= next_sda_oe_n;
    end
  end

  // register writes; soft reset key restores all reset values
  always_comb begin
    next_ref_target = ref_target;
    next_seq_cfg    = seq_cfg;
    next_flag_cfg   = flag_cfg;
    if (wr_stb) begin
      if (ptr == ADDR_SOFT_RST) begin
        if (shreg == SOFT_RST_KEY) begin
          next_ref_target = RST_REF_TARGET;
          next_seq_cfg    = '{default: RST_SEQ};
          next_flag_cfg   = RST_FLAG_CFG;
        end
      end else if (ptr == ADDR_REF_TARGET) begin
        next_ref_target = shreg[TARGET_W-1:0];
      end else if (ptr >= ADDR_POS_SEQ && ptr <= ADDR_REF_SEQ) begin
        next_seq_cfg[2'(ptr - ADDR_POS_SEQ)] = shreg;
      end else if (ptr == ADDR_FLAG_CFG) begin
        next_flag_cfg = shreg[FLAG_W-1:0];
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_target <= RST_REF_TARGET;
      seq_cfg    <= '{default: RST_SEQ};
      flag_cfg   <= RST_FLAG_CFG;
    end else begin
      ref_target <= next_ref_target;
      seq_cfg    <= next_seq_cfg;
      flag_cfg   <= next_flag_cfg;
    end
  end

  // one delay sequencer per supply, gated by the running boost
  for (genvar i = 0; i < NUM_SUP; i++) begin : g_sup
    assign want[i]    = bias_boost_on && bias_en_s && supply_enable[i];
    assign settled[i] = supply_on[i] && ready_s[i];
    lbs_supply_seq #(
      .CYC_MS (CYC_MS)
    ) u_seq (
      .clk     (clk),
      .nrst    (nrst),
      .want    (want[i]),
      .su_code (seq_cfg[i][SU_LSB+:DLY_W]),
      .sd_code (seq_cfg[i][SD_LSB+:DLY_W]),
      .on      (supply_on[i])
    );
  end

  // status, power-good, indicator and reference level
  always_comb begin
    all_settled = &(~supply_enable | settled);
    next_boost  = bias_en_s || (|supply_on);
    next_bl     = bias_en_s && all_settled;
    case (lbs_pg_sel_t'(flag_cfg[PG_SEL_LSB+:2]))
      PG_LAST: next_pg = bias_en_s && (|supply_enable) && all_settled;
      PG_POS:  next_pg = settled[SUP_POS];
      PG_NEG:  next_pg = settled[SUP_NEG];
      default: next_pg = settled[SUP_REF];
    endcase
    case (lbs_func_t'(flag_cfg[FUNC_LSB+:2]))
      FN_NONE:       flag_active = 1'h0;
      FN_POWER_GOOD: flag_active = power_good;
      FN_BACKLIGHT:  flag_active = backlight_active;
      default:       flag_active = fault_s;
    endcase
    next_ind  = flag_cfg[FLAG_POL_BIT] ? flag_active : !flag_active;
    clamp     = (ref_target > REF_CODE_MAX) ? REF_CODE_MAX : ref_target;
    next_code = clamp;
    next_mv   = MV_W'(REF_BASE_MV + REF_STEP_MV * int'(clamp));
  end

  // output registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bias_boost_on             <= 1'h0;
      power_good                <= 1'h0;
      backlight_allow           <= 1'h0;
      indicator_pin             <= 1'h1;
      reference_ldo_target_code <= RST_REF_TARGET;
      ref_level_mv              <= MV_W'(REF_BASE_MV);
    end else begin
      bias_boost_on             <= next_boost;
      power_good                <= next_pg;
      backlight_allow           <= next_bl;
      indicator_pin             <= next_ind;
      reference_ldo_target_code <= next_code;
      ref_level_mv              <= next_mv;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_ref_wr;
    wr_stb && ptr == ADDR_REF_TARGET;
  endsequence
  sequence s_soft_wr;
    wr_stb && ptr == ADDR_SOFT_RST && shreg == SOFT_RST_KEY;
  endsequence

  property p_ref_level;
    s_ref_wr ##0 (shreg[TARGET_W-1:0] <= REF_CODE_MAX) |-> ##2
      ref_level_mv == MV_W'(REF_BASE_MV + REF_STEP_MV * int'($past(shreg, 2) & 8'h3F));
  endproperty
  a_ref_level: assert property (p_ref_level)
    else $error("reference level does not follow target code");

  property p_ref_clamp;
    s_ref_wr ##0 (shreg[TARGET_W-1:0] > REF_CODE_MAX) |-> ##2
      (reference_ldo_target_code == REF_CODE_MAX && ref_level_mv == MV_W'(6000));
  endproperty
  a_ref_clamp: assert property (p_ref_clamp)
    else $error("reference target not clamped at ceiling");

  property p_flag_idle;
    (flag_cfg[1:0] == FN_NONE && !wr_stb) |=> indicator_pin != flag_cfg[FLAG_POL_BIT];
  endproperty
  a_flag_idle: assert property (p_flag_idle)
    else $error("idle indicator not at inactive level");

  property p_flag_fault;
    (flag_cfg[1:0] == FN_FAULT && fault_s && !wr_stb) |=>
      indicator_pin == flag_cfg[FLAG_POL_BIT];
  endproperty
  a_flag_fault: assert property (p_flag_fault)
    else $error("fault not shown on indicator");

  property p_pg_neg;
    (flag_cfg[3:2] == PG_NEG && settled[SUP_NEG] && !wr_stb) |=> power_good;
  endproperty
  a_pg_neg: assert property (p_pg_neg)
    else $error("power-good missing for negative pump source");

  property p_soft_reset;
    s_soft_wr |=> (ref_target == RST_REF_TARGET && flag_cfg == RST_FLAG_CFG
                   && seq_cfg[0] == RST_SEQ && seq_cfg[1] == RST_SEQ
                   && seq_cfg[2] == RST_SEQ);
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset did not restore registers");

  property p_revision;
    (ic_st == IC_ADDR && scl_fall && ack_ph && shreg[0] && ptr == ADDR_REVISION)
      |=> shreg == {REV_DIE, REV_OTP, REV_SI};
  endproperty
  a_revision: assert property (p_revision)
    else $error("revision read returned wrong byte");

  property p_boost_first;
    (supply_on != '0) |-> bias_boost_on;
  endproperty
  a_boost_first: assert property (p_boost_first)
    else $error("bias output on without boost");

  property p_bl_block;
    (|(supply_enable & ~settled)) |=> !backlight_allow;
  endproperty
  a_bl_block: assert property (p_bl_block)
    else $error("backlight allowed before outputs settled");
endmodule

/* sim/lbs_host_model.sv */
// behavioural serial host driving the register bus clock and data lines
`timescale 1ns/10ps
module lbs_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h36
) (
  input  wire logic clk,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_drv
);
  // both lines idle released
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one bit slot: data moves only in the low phase, sampled late in the high phase
  task automatic put_bit(input logic b, output logic got);
    ticks(4);
    sda_drv <= b;
    ticks(4);
    scl <= 1'b1;
    ticks(6);
    got = sda_wire;
    ticks(2);
    scl <= 1'b0;
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    ticks(4);
    sda_drv <= 1'b1;
    ticks(4);
    scl <= 1'b1;
    ticks(6);
    sda_drv <= 1'b0;
    ticks(6);
    scl <= 1'b0;
  endtask
  // stop: data rises while clock high, bus left released
  task automatic stop();
    ticks(4);
    sda_drv <= 1'b0;
    ticks(4);
    scl <= 1'b1;
    ticks(6);
    sda_drv <= 1'b1;
    ticks(6);
  endtask
  // byte out msb first, then releases data for the acknowledge slot
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) put_bit(d[i], g);
    put_bit(1'b1, g);
    ack = ~g;
  endtask
  // byte in msb first, answered with not-acknowledge to end the read
  task automatic get_byte(output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, g);
      d[i] = g;
    end
    put_bit(1'b1, g);
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k1, k2, k3;
    start();
    put_byte({DEV_ADDR, 1'b0}, k1);
    put_byte(a, k2);
    put_byte(d, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic k1, k2, k3;
    start();
    put_byte({DEV_ADDR, 1'b0}, k1);
    put_byte(a, k2);
    start();
    put_byte({DEV_ADDR, 1'b1}, k3);
    get_byte(d);
    stop();
    ok = k1 & k2 & k3;
  endtask
  // register restore key written to the soft reset place
  task automatic soft_reset(output logic ok);
    write_reg(8'h14, 8'hFF, ok);
  endtask
endmodule

/* sim/lbs_bias_regs_tb.sv */
// self-checking bench for the bias sequencing and indicator registers
`timescale 1ns/10ps
module lbs_bias_regs_tb import lbs_pkg::*; ;
  localparam int         CMS = 10;
  localparam logic [7:0] REV = 8'h53; // arbitrary revision fields 1,2,3
  logic        clk = 1'b0;
  logic        nrst, scl, sda_drv, sda_out, sda_oe_n, en, fault, bl, boost, pg, bl_ok, ind, ok;
  logic [2:0]  sup_en, sup_rdy, sup_on;
  logic [5:0]  code;
  logic [12:0] mv;
  wire         sda_wire = sda_drv & (sda_oe_n | sda_out);
  int          failures = 0;
  int          checks_done = 0;
  int          seed = 32'h4bdb94eb;
  always #5 clk = ~clk;
  lbs_bias_regs #(.DEV_ADDR(7'h36), .REV_DIE(2'h1), .REV_OTP(3'h2), .REV_SI(3'h3),
    .CYC_MS(CMS)) u_dut (.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .bias_enable_input(en), .supply_enable(sup_en),
    .supply_ready(sup_rdy), .fault_in(fault), .backlight_active(bl), .bias_boost_on(boost),
    .supply_on(sup_on), .reference_ldo_target_code(code), .ref_level_mv(mv),
    .power_good(pg), .backlight_allow(bl_ok), .indicator_pin(ind));
  lbs_host_model #(.DEV_ADDR(7'h36)) u_host (.clk(clk), .sda_wire(sda_wire), .scl(scl),
    .sda_drv(sda_drv));
  // expected values
  function automatic logic [5:0] clamp(input logic [7:0] v);
    return (v[5:0] > REF_CODE_MAX) ? REF_CODE_MAX : v[5:0];
  endfunction
  function automatic logic [15:0] exp_mv(input logic [5:0] c);
    return 16'(4000 + 50 * c);
  endfunction
  function automatic logic exp_ind(input logic [7:0] cfg, input logic p, b, f);
    logic act;
    act = cfg[1] ? (cfg[0] ? f : b) : (cfg[0] & p);
    return cfg[4] ? act : ~act;
  endfunction
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_rng(input string what, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      failures++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.write_reg(a, d, ok);
    check("write_ack", 1, ok);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    u_host.read_reg(a, d, ok);
    check("read_ack", 1, ok);
  endtask
  // edges until one supply output reaches a level, bounded
  task automatic wait_on(input int i, input logic lvl, output int cnt);
    cnt = 0;
    while (sup_on[i] !== lvl && cnt < 400) begin
      @(posedge clk);
      cnt++;
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    logic [7:0] d, v;
    int n, m, cnt;
    nrst = 1'b0;
    en = 1'b0;
    sup_en = 3'h0;
    sup_rdy = 3'h0;
    fault = 1'b0;
    bl = 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    check("ind_rst", 1, ind);
    check("mv_rst", 16'd4000, mv);
    // reset values, unmapped 0x15 and the revision byte
    for (int a = 8'h0F; a <= 8'h16; a++) begin
      rd(8'(a), d);
      check("reg_rst", (a == 8'h16) ? REV : 8'h00, d);
    end
    wr(ADDR_REVISION, 8'h00);
    rd(ADDR_REVISION, d);
    check("rev_ro", REV, d);
    // target code with ceiling corners and random values
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'h28 : (i == 1) ? 8'h29 : (i == 2) ? 8'hFF : 8'($random(seed));
      wr(ADDR_REF_TARGET, v);
      rd(ADDR_REF_TARGET, d);
      check("target_rd", v & 8'h3F, d);
      check("target_code", clamp(v), code);
      check("target_mv", exp_mv(clamp(v)), mv);
    end
    // every indicator function at both polarities with random status inputs
    for (int f = 0; f < 8; f++) begin
      v = 8'($random(seed));
      v[1:0] = f[1:0];
      v[4] = f[2];
      fault <= (f == 3) | 1'($random(seed)); // fault shown at least once
      bl <= 1'($random(seed));
      wr(ADDR_FLAG_CFG, v);
      rd(ADDR_FLAG_CFG, d);
      check("flag_rd", v & 8'h1F, d);
      check("ind", exp_ind(v, 1'b0, bl, fault), ind);
    end
    // per supply start-up and shutdown delays, power-good source, backlight gate
    for (int i = 0; i < 3; i++) begin
      n = {$random(seed)} % 16;
      m = {$random(seed)} % 16;
      wr(ADDR_POS_SEQ + 8'(i), {n[3:0], m[3:0]});
      rd(ADDR_POS_SEQ + 8'(i), d);
      check("seq_rd", {n[3:0], m[3:0]}, d);
      sup_rdy <= 3'h7;
      sup_en <= 3'h1 << i;
      en <= 1'b1;
      wait_on(i, 1'b1, cnt);
      check_rng("su_dly", n * CMS + 2, n * CMS + 10, cnt);
      check("boost", 1, boost);
      wr(ADDR_FLAG_CFG, 8'h11 | 8'((i + 1) << 2));
      check("pg_sel", 3'h7, {pg, ind, bl_ok});
      sup_rdy <= 3'h0;
      repeat (5) @(posedge clk);
      check("pg_unready", 3'h0, {pg, ind, bl_ok});
      en <= 1'b0;
      wait_on(i, 1'b0, cnt);
      check_rng("sd_dly", m * CMS + 2, m * CMS + 10, cnt);
      repeat (4) @(posedge clk);
      check("boost_off", 0, boost);
    end
    // last-supply selection against single sources, negative pump not yet settled
    sup_en <= 3'h3;
    sup_rdy <= 3'h1;
    en <= 1'b1;
    wait_on(0, 1'b1, cnt);
    wait_on(1, 1'b1, cnt);
    for (int j = 0; j < 3; j++) begin
      wr(ADDR_FLAG_CFG, 8'h11 | 8'(j << 2));
      check("pg_src", (j == 1), pg);
    end
    check("bl_gate", 0, bl_ok);
    sup_rdy <= 3'h3;
    wr(ADDR_FLAG_CFG, 8'h11);
    check("pg_last", 3'h7, {pg, ind, bl_ok});
    // wrong key ignored, proper key restores reset values
    wr(ADDR_SOFT_RST, 8'h55);
    rd(ADDR_FLAG_CFG, d);
    check("soft_wrong", 8'h11, d);
    u_host.soft_reset(ok);
    check("soft_ack", 1, ok);
    rd(ADDR_FLAG_CFG, d);
    check("soft_flag", 8'h00, d);
    rd(ADDR_POS_SEQ, d);
    check("soft_seq", 8'h00, d);
    check("soft_code", 6'h00, code);
    // zero delays after restore: shutdown and start-up take only pipeline time
    en <= 1'b0;
    wait_on(1, 1'b0, cnt);
    check_rng("sd_zero", 2, 10, cnt);
    en <= 1'b1;
    wait_on(0, 1'b1, cnt);
    check_rng("su_zero", 2, 10, cnt);
    // foreign address gets no acknowledge
    u_host.start();
    u_host.put_byte(8'hAA, ok);
    u_host.stop();
    check("foreign_nack", 0, ok);
    stop_test();
  end
  // hang guard
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    stop_test();
  end
endmodule
